// file: common/rtca_defines.svh
// Notes on behaviour
// - oscillator control bit 7 turns automatic gain control on (1) or off (0).
// - oscillator control bit 6 picks crystal mode (1) or self-oscillate mode (0).
// - oscillator control bit 5 turns doubled oscillator bias on (1) or off (0).
// - read-only bit 4 shows 1 when the oscillator is enabled and oscillation amplitude is sufficient.
// - bit 3 enables the slow internal oscillator as source, overriding mode select.
// - control bits 2:0 and configuration bits 5:4 read zero; writes ignored.
// - configuration bit 7 enables automatic load capacitance stepping.
// - read-only bit 6 is 1 once load capacitance equals target, else 0.
// - configuration bits 3:0 hold the target load capacitance; reset value unfixed.
// - snapshot bytes at 0x00..0x03 form the 32-bit timer window, LSB at 0x00.
// - set command copies snapshot into timer; capture command copies timer into snapshot.
// - alarm bytes at 0x08..0x0B hold the 32-bit match value, LSB at 0x08.
// - oscillator control sits at 0x05, oscillator configuration at 0x06.
// - writing 1 to the set command starts it; hardware clears it when finished.
// - writing 1 to the capture command starts it; hardware clears it when done.
// - an alarm event is raised when timer exactly equals the match value.
// - with auto reset enabled the timer clears one cycle after an alarm event.
`ifndef RTCA_DEFINES_SVH
`define RTCA_DEFINES_SVH
// register indexes; byte address is four times the index
`define RTCA_IDX_SNAP0 4'h0
`define RTCA_IDX_SNAP1 4'h1
`define RTCA_IDX_SNAP2 4'h2
`define RTCA_IDX_SNAP3 4'h3
`define RTCA_IDX_CTRL 4'h4
`define RTCA_IDX_OSC_CTRL 4'h5
`define RTCA_IDX_LOAD_CFG 4'h6
`define RTCA_IDX_ALARM_MATCH_BYTE0 4'h8
`define RTCA_IDX_ALARM_MATCH_BYTE1 4'h9
`define RTCA_IDX_ALARM_MATCH_BYTE2 4'hA
`define RTCA_IDX_ALARM_MATCH_BYTE3 4'hB
`define RTCA_IDX_IRQ_STAT 4'hC
`define RTCA_IDX_IRQ_MASK 4'hD
// control register bits
`define RTCA_CTRL_OSC_EN 7
`define RTCA_CTRL_RUN 4
`define RTCA_CTRL_ALARM_EN 3
`define RTCA_CTRL_AUTORESET 2
`define RTCA_CTRL_SET 1
`define RTCA_CTRL_CAP 0
// oscillator control bits
`define RTCA_OSC_GAIN 7
`define RTCA_OSC_CRYSTAL_MODE_SELECT 6
`define RTCA_OSC_BIAS2 5
`define RTCA_OSC_VALID 4
`define RTCA_OSC_SLOW 3
// load configuration bits
`define RTCA_LOAD_STEP_EN 7
`define RTCA_LOAD_READY 6
`define RTCA_LOAD_TGT_MSB 3
// interrupt status bits
`define RTCA_IRQ_ALARM 0
`define RTCA_IRQ_SET 1
`define RTCA_IRQ_CAP 2
`define RTCA_IRQ_LOAD 3
`define RTCA_IRQ_BITS 4
// reset values
`define RTCA_RST_BYTE 8'h00
`define RTCA_RST_LOAD_TGT 4'h0
// one load capacitance step every so many nanoseconds
`define RTCA_LOAD_STEP_NS 1000
`define RTCA_CLK_MHZ 100
`define RTCA_LOAD_STEP_CYC ((`RTCA_LOAD_STEP_NS * `RTCA_CLK_MHZ + 999) / 1000)
`endif

// file: common/rtca_pkg.sv
package rtca_pkg;
	typedef logic [7:0] rtca_byte_t;
	typedef logic [31:0] rtca_word_t;
	typedef enum logic [1:0] {
		LD_IDLE,
		LD_WAIT,
		LD_STEP
	} rtca_load_e;
endpackage : rtca_pkg

// file: common/rtca_if.sv
`timescale 1ns/1ns
`default_nettype none
interface rtca_if;
	logic [31:0] snap_value;
	logic [31:0] alarm_value;
	logic [31:0] timer_value;
	logic set_go;
	logic cap_go;
	logic run;
	logic alarm_en;
	logic auto_reset;
	logic set_done;
	logic cap_done;
	logic alarm_hit;
	modport ctl (
		output snap_value, alarm_value, set_go, cap_go, run, alarm_en, auto_reset,
		input timer_value, set_done, cap_done, alarm_hit
	);
	modport tmr (
		input snap_value, alarm_value, set_go, cap_go, run, alarm_en, auto_reset,
		output timer_value, set_done, cap_done, alarm_hit
	);
endinterface : rtca_if
`default_nettype wire

// file: design/rtca_timer.sv
`timescale 1ns/1ns
`default_nettype none
module rtca_timer
	import rtca_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	rtca_if.tmr tif
);
	rtca_word_t timer_reg;
	logic hit_reg;
	logic set_done_reg;
	logic cap_done_reg;
	logic match;
	logic match_q;

	// exact equality only; a match held while stopped would re-fire, so gate on change
	assign match = tif.alarm_en && (timer_reg == tif.alarm_value);

	// timer: set wins over auto reset, auto reset over counting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_reg <= '0;
		end else if (tif.set_go) begin
			timer_reg <= tif.snap_value;
		end else if (hit_reg && tif.auto_reset) begin
			timer_reg <= '0;
		end else if (tif.run) begin
			timer_reg <= timer_reg + 32'h00000001;
		end
	end

	// alarm pulse lasts one cycle, only on a fresh match; a stopped timer held on
	// the match value must not pulse again every other cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hit_reg <= 1'b0;
			match_q <= 1'b0;
		end else begin
			hit_reg <= match && !match_q;
			match_q <= match;
		end
	end

	// command completion pulses, one cycle after the go pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			set_done_reg <= 1'b0;
			cap_done_reg <= 1'b0;
		end else begin
			set_done_reg <= tif.set_go;
			cap_done_reg <= tif.cap_go;
		end
	end

	assign tif.timer_value = timer_reg;
	assign tif.alarm_hit = hit_reg;
	assign tif.set_done = set_done_reg;
	assign tif.cap_done = cap_done_reg;
endmodule : rtca_timer
`default_nettype wire

// file: design/rtca_top.sv
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "rtca_defines.svh"
module rtca_top
	import rtca_pkg::*;
#(
	parameter int unsigned LOAD_STEP_CYC = `RTCA_LOAD_STEP_CYC,
	parameter logic [3:0] LOAD_TGT_RST = `RTCA_RST_LOAD_TGT
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic osc_amplitude_ok,
	output logic osc_enable,
	output logic gain_control_enable,
	output logic crystal_mode_select,
	output logic bias_double_enable,
	output logic internal_slow_oscillator,
	output logic [3:0] load_cap_value,
	output logic alarm_event,
	output logic irq
);
	localparam int unsigned STEP_W = $clog2(LOAD_STEP_CYC + 1);

	rtca_if tif ();

	// bus decode
	logic setup_ph;
	logic wr_en;
	logic addr_ok;
	logic [3:0] idx;
	logic [7:0] wbyte;

	// software registers
	rtca_byte_t snap_reg [4];
	rtca_byte_t alarm_reg [4];
	logic osc_en_reg;
	logic run_reg;
	logic alarm_en_reg;
	logic autoreset_reg;
	logic set_cmd_reg;
	logic cap_cmd_reg;
	logic gain_reg;
	logic crystal_mode_select_reg;
	logic bias2_reg;
	logic slow_reg;
	logic step_en_reg;
	logic [3:0] load_tgt_reg;
	logic [3:0] load_cur_reg;
	logic alarm_flag_reg;
	logic [`RTCA_IRQ_BITS-1:0] irq_stat_reg;
	logic [`RTCA_IRQ_BITS-1:0] irq_mask_reg;
	logic [`RTCA_IRQ_BITS-1:0] irq_evt;
	logic [31:0] prdata_reg;
	logic [31:0] rd_next;
	logic set_go_reg;
	logic cap_go_reg;

	// oscillator status path
	logic amp_meta_reg;
	logic amp_sync_reg;
	logic valid_flag;
	logic load_ready;
	logic load_ready_q;

	// load stepping machine
	rtca_load_e ld_state;
	logic [STEP_W-1:0] step_cnt;

	// the bus always answers in the access phase, so no wait states are needed
	assign setup_ph = psel && !penable;
	assign idx = paddr[5:2];
	assign addr_ok = (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00) && (idx != 4'h7)
		&& (idx <= `RTCA_IDX_IRQ_MASK);
	assign wr_en = psel && penable && pwrite && addr_ok && pstrb[0];
	assign wbyte = pwdata[7:0];
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;

	// command go pulses: only a write of 1 while idle starts a transfer
	assign tif.set_go = set_go_reg;
	assign tif.cap_go = cap_go_reg;
	assign tif.snap_value = {snap_reg[3], snap_reg[2], snap_reg[1], snap_reg[0]};
	assign tif.alarm_value = {alarm_reg[3], alarm_reg[2], alarm_reg[1], alarm_reg[0]};
	assign tif.run = run_reg;
	assign tif.alarm_en = alarm_en_reg;
	assign tif.auto_reset = autoreset_reg;

	rtca_timer u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.tif(tif)
	);

	// snapshot bytes: software writes, capture completion overwrites
	generate
		for (genvar b = 0; b < 4; b++) begin : g_snap
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					snap_reg[b] <= `RTCA_RST_BYTE;
				end else if (tif.cap_done) begin
					snap_reg[b] <= tif.timer_value[8*b +: 8];
				end else if (wr_en && idx == 4'(b)) begin
					snap_reg[b] <= wbyte;
				end
			end

			// alarm bytes; software is expected to hold the alarm off while changing them
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					alarm_reg[b] <= `RTCA_RST_BYTE;
				end else if (wr_en && idx == (`RTCA_IDX_ALARM_MATCH_BYTE0 + 4'(b))) begin
					alarm_reg[b] <= wbyte;
				end
			end
		end
	endgenerate

	// control register: enables and auto reset selection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_en_reg <= 1'b0;
			run_reg <= 1'b0;
			alarm_en_reg <= 1'b0;
			autoreset_reg <= 1'b0;
		end else if (wr_en && idx == `RTCA_IDX_CTRL) begin
			osc_en_reg <= wbyte[`RTCA_CTRL_OSC_EN];
			run_reg <= wbyte[`RTCA_CTRL_RUN];
			alarm_en_reg <= wbyte[`RTCA_CTRL_ALARM_EN];
			autoreset_reg <= wbyte[`RTCA_CTRL_AUTORESET];
		end
	end

	// set command bit: a write of 1 raises it, completion clears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			set_cmd_reg <= 1'b0;
			set_go_reg <= 1'b0;
		end else begin
			set_go_reg <= wr_en && idx == `RTCA_IDX_CTRL && wbyte[`RTCA_CTRL_SET] && !set_cmd_reg;
			if (wr_en && idx == `RTCA_IDX_CTRL && wbyte[`RTCA_CTRL_SET]) begin
				set_cmd_reg <= 1'b1;
			end else if (tif.set_done) begin
				set_cmd_reg <= 1'b0;
			end
		end
	end

	// capture command bit, same shape as the set command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_cmd_reg <= 1'b0;
			cap_go_reg <= 1'b0;
		end else begin
			cap_go_reg <= wr_en && idx == `RTCA_IDX_CTRL && wbyte[`RTCA_CTRL_CAP] && !cap_cmd_reg;
			if (wr_en && idx == `RTCA_IDX_CTRL && wbyte[`RTCA_CTRL_CAP]) begin
				cap_cmd_reg <= 1'b1;
			end else if (tif.cap_done) begin
				cap_cmd_reg <= 1'b0;
			end
		end
	end

	// alarm flag: asserted one cycle per event, clears itself on the next cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_flag_reg <= 1'b0;
		end else begin
			alarm_flag_reg <= tif.alarm_hit && alarm_en_reg;
		end
	end

	// oscillator control fields; bits 2:0 are never stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain_reg <= 1'b0;
			crystal_mode_select_reg <= 1'b0;
			bias2_reg <= 1'b0;
			slow_reg <= 1'b0;
		end else if (wr_en && idx == `RTCA_IDX_OSC_CTRL) begin
			gain_reg <= wbyte[`RTCA_OSC_GAIN];
			crystal_mode_select_reg <= wbyte[`RTCA_OSC_CRYSTAL_MODE_SELECT];
			bias2_reg <= wbyte[`RTCA_OSC_BIAS2];
			slow_reg <= wbyte[`RTCA_OSC_SLOW];
		end
	end

	// load configuration fields; bits 5:4 and the status bit 6 are never stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_en_reg <= 1'b0;
			load_tgt_reg <= LOAD_TGT_RST; // same start as the stepped value, so ready after reset
		end else if (wr_en && idx == `RTCA_IDX_LOAD_CFG) begin
			step_en_reg <= wbyte[`RTCA_LOAD_STEP_EN];
			load_tgt_reg <= wbyte[`RTCA_LOAD_TGT_MSB:0];
		end
	end

	// amplitude detector comes from the analog side, so it is synchronised first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			amp_meta_reg <= 1'b0;
			amp_sync_reg <= 1'b0;
		end else begin
			amp_meta_reg <= osc_amplitude_ok;
			amp_sync_reg <= amp_meta_reg;
		end
	end

	// a stale detector level must not show valid once the oscillator is off
	assign valid_flag = osc_en_reg && amp_sync_reg;

	// load stepping: one unit toward the target every LOAD_STEP_CYC + 2 cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ld_state <= LD_IDLE;
			step_cnt <= '0;
			load_cur_reg <= LOAD_TGT_RST;
		end else begin
			case (ld_state)
				LD_IDLE: begin
					step_cnt <= '0;
					if (step_en_reg && load_cur_reg != load_tgt_reg) begin
						ld_state <= LD_WAIT;
					end
				end
				LD_WAIT: begin
					if (!step_en_reg) begin
						ld_state <= LD_IDLE;
					end else if (step_cnt == STEP_W'(LOAD_STEP_CYC - 1)) begin
						ld_state <= LD_STEP;
					end else begin
						step_cnt <= step_cnt + 1'b1;
					end
				end
				LD_STEP: begin
					if (load_cur_reg < load_tgt_reg) begin
						load_cur_reg <= load_cur_reg + 4'h1;
					end else if (load_cur_reg > load_tgt_reg) begin
						load_cur_reg <= load_cur_reg - 4'h1;
					end
					ld_state <= LD_IDLE;
				end
				default: begin
					ld_state <= LD_IDLE;
				end
			endcase
		end
	end

	// ready only when nothing is left to step
	assign load_ready = (load_cur_reg == load_tgt_reg);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_ready_q <= 1'b1;
		end else begin
			load_ready_q <= load_ready;
		end
	end

	// interrupt events: alarm, set done, capture done, load reached
	always_comb begin
		irq_evt = '0;
		irq_evt[`RTCA_IRQ_ALARM] = tif.alarm_hit && alarm_en_reg;
		irq_evt[`RTCA_IRQ_SET] = tif.set_done;
		irq_evt[`RTCA_IRQ_CAP] = tif.cap_done;
		irq_evt[`RTCA_IRQ_LOAD] = load_ready && !load_ready_q;
	end

	// sticky status, write one to clear; a new event in the same cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_reg <= '0;
		end else if (wr_en && idx == `RTCA_IDX_IRQ_STAT) begin
			irq_stat_reg <= (irq_stat_reg & ~wbyte[`RTCA_IRQ_BITS-1:0]) | irq_evt;
		end else begin
			irq_stat_reg <= irq_stat_reg | irq_evt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_reg <= '0;
		end else if (wr_en && idx == `RTCA_IDX_IRQ_MASK) begin
			irq_mask_reg <= wbyte[`RTCA_IRQ_BITS-1:0];
		end
	end

	// read mux; unused bits and unmapped slots read zero
	always_comb begin
		rd_next = '0;
		case (idx)
			`RTCA_IDX_SNAP0, `RTCA_IDX_SNAP1, `RTCA_IDX_SNAP2, `RTCA_IDX_SNAP3: begin
				rd_next[7:0] = snap_reg[idx[1:0]];
			end
			`RTCA_IDX_CTRL: begin
				rd_next[`RTCA_CTRL_OSC_EN] = osc_en_reg;
				rd_next[`RTCA_CTRL_RUN] = run_reg;
				rd_next[`RTCA_CTRL_ALARM_EN] = alarm_en_reg;
				rd_next[`RTCA_CTRL_AUTORESET] = alarm_flag_reg;
				rd_next[`RTCA_CTRL_SET] = set_cmd_reg;
				rd_next[`RTCA_CTRL_CAP] = cap_cmd_reg;
			end
			`RTCA_IDX_OSC_CTRL: begin
				rd_next[`RTCA_OSC_GAIN] = gain_reg;
				rd_next[`RTCA_OSC_CRYSTAL_MODE_SELECT] = crystal_mode_select_reg;
				rd_next[`RTCA_OSC_BIAS2] = bias2_reg;
				rd_next[`RTCA_OSC_VALID] = valid_flag;
				rd_next[`RTCA_OSC_SLOW] = slow_reg;
			end
			`RTCA_IDX_LOAD_CFG: begin
				rd_next[`RTCA_LOAD_STEP_EN] = step_en_reg;
				rd_next[`RTCA_LOAD_READY] = load_ready;
				rd_next[`RTCA_LOAD_TGT_MSB:0] = load_tgt_reg;
			end
			`RTCA_IDX_ALARM_MATCH_BYTE0, `RTCA_IDX_ALARM_MATCH_BYTE1, `RTCA_IDX_ALARM_MATCH_BYTE2, `RTCA_IDX_ALARM_MATCH_BYTE3: begin
				rd_next[7:0] = alarm_reg[idx[1:0]];
			end
			`RTCA_IDX_IRQ_STAT: begin
				rd_next[`RTCA_IRQ_BITS-1:0] = irq_stat_reg;
			end
			`RTCA_IDX_IRQ_MASK: begin
				rd_next[`RTCA_IRQ_BITS-1:0] = irq_mask_reg;
			end
			default: begin
				rd_next = '0;
			end
		endcase
	end

	// read data is captured in the setup phase so it comes from a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= '0;
		end else if (setup_ph && !pwrite) begin
			prdata_reg <= addr_ok ? rd_next : 32'h00000000;
		end
	end

	// analog controls; the slow oscillator overrides the crystal mode choice
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain_control_enable <= 1'b0;
			crystal_mode_select <= 1'b0;
			bias_double_enable <= 1'b0;
			internal_slow_oscillator <= 1'b0;
			osc_enable <= 1'b0;
			load_cap_value <= 4'h0;
		end else begin
			gain_control_enable <= gain_reg;
			crystal_mode_select <= crystal_mode_select_reg && !slow_reg;
			bias_double_enable <= bias2_reg;
			internal_slow_oscillator <= slow_reg && osc_en_reg;
			osc_enable <= osc_en_reg;
			load_cap_value <= load_cur_reg;
		end
	end

	assign prdata = prdata_reg;
	assign alarm_event = alarm_flag_reg;
	assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule : rtca_top
`default_nettype wire

// file: testbench/rtca_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
module rtca_top_sva #(
	parameter int unsigned LOAD_STEP_CYC = 100
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic osc_amplitude_ok,
	input wire logic gain_control_enable,
	input wire logic crystal_mode_select,
	input wire logic bias_double_enable,
	input wire logic internal_slow_oscillator,
	input wire logic [3:0] load_cap_value,
	input wire logic alarm_event
);
	logic acc, wr_osc, rd_osc, rd_load;
	int unsigned gap;
	// access-phase decodes of the register bus
	assign acc = psel && penable && pready;
	assign wr_osc = acc && pwrite && pstrb[0] && paddr == 8'h14;
	assign rd_osc = acc && !pwrite && paddr == 8'h14;
	assign rd_load = acc && !pwrite && paddr == 8'h18;
	// cycles since the load capacitance last moved
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap <= 0;
		end else begin
			gap <= $changed(load_cap_value) ? 0 : gap + 1;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_gain; wr_osc |-> ##2 gain_control_enable == $past(pwdata[7], 2); endproperty
	a_gain: assert property (p_gain) else $error("gain enable wrong");
	property p_crystal_mode_select;
		wr_osc |-> ##2 crystal_mode_select == ($past(pwdata[6], 2) && !$past(pwdata[3], 2));
	endproperty
	a_crystal_mode_select: assert property (p_crystal_mode_select) else $error("crystal select wrong");
	property p_bias; wr_osc |-> ##2 bias_double_enable == $past(pwdata[5], 2); endproperty
	a_bias: assert property (p_bias) else $error("bias double wrong");
	property p_slow; wr_osc && !pwdata[3] |-> ##2 !internal_slow_oscillator; endproperty
	a_slow: assert property (p_slow) else $error("slow osc on");
	property p_rsv; rd_osc |-> prdata[2:0] == 3'h0 && prdata[31:8] == 24'h000000; endproperty
	a_rsv: assert property (p_rsv) else $error("unused osc bits set");
	property p_rsv2; rd_load |-> prdata[5:4] == 2'h0; endproperty
	a_rsv2: assert property (p_rsv2) else $error("unused load bits set");
	property p_valid; !osc_amplitude_ok [*6] ##1 rd_osc |-> !prdata[4]; endproperty
	a_valid: assert property (p_valid) else $error("valid without amplitude");
	property p_pulse; alarm_event |=> !alarm_event; endproperty
	a_pulse: assert property (p_pulse) else $error("alarm pulse too long");
	property p_err; acc && (paddr[5:2] == 4'h7 || paddr[5:2] > 4'hD) |-> pslverr; endproperty
	a_err: assert property (p_err) else $error("unmapped not refused");
	property p_step;
		$changed(load_cap_value) |-> gap >= LOAD_STEP_CYC && (load_cap_value ==
			$past(load_cap_value) + 4'h1 || load_cap_value == $past(load_cap_value) - 4'h1);
	endproperty
	a_step: assert property (p_step) else $error("load step wrong");
	c_alarm: cover property (alarm_event);
	c_ready: cover property (rd_load && prdata[6]);
	c_err: cover property (acc && pslverr);
endmodule : rtca_top_sva
bind rtca_top rtca_top_sva #(.LOAD_STEP_CYC(LOAD_STEP_CYC)) u_sva (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .osc_amplitude_ok,
	.gain_control_enable, .crystal_mode_select, .bias_double_enable,
	.internal_slow_oscillator, .load_cap_value, .alarm_event);
`default_nettype wire

// file: testbench/rtca_apb_host.sv
`timescale 1ns/1ns
`default_nettype none
// bus master standing in for the processor core
module rtca_apb_host (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		pstrb = 4'hF;
	end
	// one transfer; the request stays put until pready is seen high
	task automatic xfer(input logic wr, input logic [3:0] idx, input logic [7:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~pwdata; // stale data must not look valid
	endtask : xfer
endmodule : rtca_apb_host
`default_nettype wire

// file: testbench/rtca_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module rtca_top_bench;
	import rtca_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, amp_ok, errv;
	logic osc_en, gain_en, xtal, bias2, slow, alarm_ev, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [3:0] pstrb, cap_v;
	logic [7:0] snap [4] = '{8'h78, 8'h56, 8'h34, 8'h12};
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	// short load step keeps the stepping test brief
	rtca_top #(.LOAD_STEP_CYC(2)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_amplitude_ok(amp_ok),
		.osc_enable(osc_en), .gain_control_enable(gain_en), .crystal_mode_select(xtal),
		.bias_double_enable(bias2), .internal_slow_oscillator(slow),
		.load_cap_value(cap_v), .alarm_event(alarm_ev), .irq(irq));
	rtca_apb_host h (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// a hang ends the run after a fixed cycle budget
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] idx, input logic [7:0] d);
		h.xfer(1'b1, idx, d, rdv, errv);
	endtask : wr
	task automatic rdc(input logic [3:0] idx, input logic [31:0] exp);
		h.xfer(1'b0, idx, 8'h00, rdv, errv);
		chk(rdv, exp);
	endtask : rdc
	// bounded poll until the masked bits reach the wanted value
	task automatic poll(input logic [3:0] idx, input logic [7:0] m, input logic [7:0] v);
		h.xfer(1'b0, idx, 8'h00, rdv, errv);
		for (int i = 0; i < 100 && (rdv[7:0] & m) !== v; i++) h.xfer(1'b0, idx, 8'h00, rdv, errv);
		chk(rdv[7:0] & m, v);
	endtask : poll
	task automatic t_reset();
		logic [3:0] idx [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h8, 4'h9, 4'hA, 4'hB};
		foreach (idx[i]) rdc(idx[i], 32'h0);
		poll(4'h6, 8'hB0, 8'h00);
	endtask : t_reset
	task automatic t_osc();
		wr(4'h5, 8'hFF);
		rdc(4'h5, 32'hE8);
		repeat (2) @(posedge pclk);
		chk({gain_en, xtal, bias2, slow}, 4'b1010);
		wr(4'h4, 8'h80);
		repeat (2) @(posedge pclk);
		chk({osc_en, slow}, 2'b11);
		amp_ok <= 1'b1;
		wr(4'h5, 8'h40);
		repeat (6) @(posedge pclk);
		chk({gain_en, xtal, bias2, slow}, 4'b0100);
		rdc(4'h5, 32'h50);
		wr(4'h4, 8'h00);
		repeat (6) @(posedge pclk);
		rdc(4'h5, 32'h40);
		amp_ok <= 1'b0;
	endtask : t_osc
	// step to a target with the load interrupt masked, then unmasked and cleared
	task automatic t_load();
		wr(4'hD, 8'h00);
		wr(4'h6, 8'hBF);
		rdc(4'h6, 32'h8F);
		poll(4'h6, 8'h40, 8'h40);
		chk({cap_v, irq}, 5'h1E);
		wr(4'hD, 8'h08);
		@(posedge pclk);
		chk(irq, 1'b1);
		wr(4'hC, 8'h08);
		@(posedge pclk);
		chk(irq, 1'b0);
		wr(4'h6, 8'h03);
		repeat (20) @(posedge pclk);
		rdc(4'h6, 32'h03);
		chk(cap_v, 4'hF);
	endtask : t_load
	task automatic t_setcap();
		foreach (snap[i]) wr(4'(i), snap[i]);
		wr(4'h4, 8'h02);
		poll(4'h4, 8'h02, 8'h00);
		foreach (snap[i]) wr(4'(i), 8'hAA);
		wr(4'h4, 8'h01);
		poll(4'h4, 8'h01, 8'h00);
		foreach (snap[i]) rdc(4'(i), {24'h000000, snap[i]});
		poll(4'hC, 8'h06, 8'h06);
	endtask : t_setcap
	task automatic t_alarm();
		logic [7:0] m [4] = '{8'h80, 8'h56, 8'h34, 8'h12};
		wr(4'h4, 8'h80);
		foreach (m[i]) wr(4'(i + 8), m[i]);
		wr(4'hC, 8'h0F);
		wr(4'hD, 8'h01);
		wr(4'h4, 8'h9C);
		for (int i = 0; i < 60 && alarm_ev !== 1'b1; i++) @(posedge pclk);
		chk(alarm_ev, 1'b1);
		wr(4'h4, 8'h80);
		chk(irq, 1'b1);
		wr(4'h4, 8'h81);
		poll(4'h4, 8'h01, 8'h00);
		rdc(4'h3, 32'h0);
		rdc(4'h1, 32'h0);
		wr(4'hC, 8'h01);
		@(posedge pclk);
		chk(irq, 1'b0);
	endtask : t_alarm
	task automatic t_unmapped();
		h.xfer(1'b0, 4'h7, 8'h00, rdv, errv);
		chk({errv, rdv[7:0]}, 9'h100);
		h.xfer(1'b1, 4'hE, 8'h55, rdv, errv);
		chk(errv, 1'b1);
	endtask : t_unmapped
	task automatic final_report();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report
	initial begin
		presetn = 1'b0;
		amp_ok = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_osc();
		t_load();
		t_setcap();
		t_alarm();
		t_unmapped();
		final_report();
	end
endmodule : rtca_top_bench
`default_nettype wire
